/* core/sidbsp_port_top.sv */
`timescale 1ns/1ps
// Operation
// R01 - separate read output port and write input port into one array
// R02 - read and write addresses share a bus, alternating true clock edges
// R03 - each address holds two consecutive words, moved together as a burst
// R04 - one data word per rising edge of true and complement clock
// R05 - bypass pin high: read data two cycles after address capture
// R06 - bypass pin low: read data one cycle after address capture
// R07 - valid flag high exactly while read outputs carry burst words; valid is high one true cycle, outputs keep the last burst until the next read
// R08 - each port starts accesses only when its own select is asserted
// R09 - every synchronous input captured in a true or complement clock register
// R10 - every read data output launched from a clocked output register
// R11 - array write completes internally after capture, no write strobe
// R12 - only rising edges of true and complement clock are used
// R13 - free-running echo clock pair aligned with read data
// R14 - controller keeps link clocks at or below 250 MHz
// R15 - burst word one on true edge, word two on next complement edge
// R16 - unselected cycle leaves array unchanged and starts no read
module sidbsp_port_top
	import sidbsp_pkg::*;
(
	// system clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	// link clocks
	input wire logic I_K_CLK,
	input wire logic I_K_CLK_N,
	// link control and address
	input wire logic I_PLL_BYPASS_SELECT,
	input wire logic I_READ_PORT_SELECT_N,
	input wire logic I_WRITE_PORT_SELECT_N,
	input wire logic [ADDR_W-1:0] I_ADDR,
	// write data port
	input wire logic [DATA_W-1:0] I_WDATA,
	// read data port
	output logic [DATA_W-1:0] O_RDATA_K,
	output logic [DATA_W-1:0] O_RDATA_KN,
	output logic O_READ_VALID_FLAG,
	output logic O_ECHO_TIMING_OUT,
	output logic O_ECHO_TIMING_OUT_N,
	// system side status
	output logic O_WRITE_DONE
);

	// memory array shared by both ports
	logic [DATA_W-1:0] mem [DEPTH];

	// system domain state
	logic sys_rst_reg;
	logic sys_rst_next;
	logic wr_tog_d_reg;
	logic wr_tog_d_next;
	logic write_done_reg;
	logic write_done_next;
	logic wr_tog_s;

	// link domain synchronised levels
	logic k_rst;
	logic kn_rst;
	logic byp_k;

	// true clock input registers
	logic [ADDR_W-1:0] addr_in_reg;
	logic [ADDR_W-1:0] addr_in_next;
	logic [DATA_W-1:0] wdata_in_reg;
	logic [DATA_W-1:0] wdata_in_next;
	logic rps_n_in_reg;
	logic rps_n_in_next;
	logic wps_n_in_reg;
	logic wps_n_in_next;
	sidbsp_slot_t slot_reg;
	sidbsp_slot_t slot_next;
	sidbsp_slot_t cap_slot_reg;
	sidbsp_slot_t cap_slot_next;

	// true clock read pipeline and write bookkeeping
	logic rd_pend_reg;
	logic rd_pend_next;
	logic [ADDR_W-1:0] rd_addr_p_reg;
	logic [ADDR_W-1:0] rd_addr_p_next;
	logic [DATA_W-1:0] rdata_k_reg;
	logic [DATA_W-1:0] rdata_k_next;
	logic [DATA_W-1:0] rd_w1_stage_reg;
	logic [DATA_W-1:0] rd_w1_stage_next;
	logic valid_reg;
	logic valid_next;
	logic wr_tog_reg;
	logic wr_tog_next;
	logic echo_k_reg;
	logic echo_k_next;

	// complement clock state
	logic [DATA_W-1:0] wdata_kn_reg;
	logic [DATA_W-1:0] wdata_kn_next;
	logic [DATA_W-1:0] rdata_kn_reg;
	logic [DATA_W-1:0] rdata_kn_next;
	logic echo_kn_reg;
	logic echo_kn_next;

	// decoded requests
	logic rd_req;
	logic launch;
	logic [ADDR_W-1:0] launch_addr;
	logic wr_en;
	logic [ADDR_W:0] w0_idx;
	logic [ADDR_W:0] w1_idx;

	// crossings into and out of the link domains
	sidbsp_sync u_sync_krst (.i_clk(I_K_CLK), .i_d(sys_rst_reg), .o_q(k_rst));
	sidbsp_sync u_sync_knrst (.i_clk(I_K_CLK_N), .i_d(sys_rst_reg), .o_q(kn_rst));
	sidbsp_sync u_sync_byp (.i_clk(I_K_CLK), .i_d(I_PLL_BYPASS_SELECT), .o_q(byp_k));
	sidbsp_sync u_sync_wtog (.i_clk(I_SYS_CLK), .i_d(wr_tog_reg), .o_q(wr_tog_s));

	// system side: reset register and write-commit pulse from toggle
	always_comb begin
		sys_rst_next = ~I_RESETN;
		wr_tog_d_next = wr_tog_s;
		write_done_next = wr_tog_s ^ wr_tog_d_reg;
		if (!I_RESETN) begin
			wr_tog_d_next = wr_tog_s;
			write_done_next = FLAG_RST;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		sys_rst_reg <= sys_rst_next;
		wr_tog_d_reg <= wr_tog_d_next;
		write_done_reg <= write_done_next;
	end

	// request decode on the registered inputs
	always_comb begin
		rd_req = (cap_slot_reg == SLOT_READ) && !rps_n_in_reg; // see R08
		launch = byp_k ? rd_pend_reg : rd_req; // see R05 see R06
		launch_addr = byp_k ? rd_addr_p_reg : addr_in_reg;
		wr_en = (cap_slot_reg == SLOT_WRITE) && !wps_n_in_reg; // see R08 see R16
		w0_idx = word_index(addr_in_reg, 1'h0); // see R03
		w1_idx = word_index(addr_in_reg, 1'h1);
	end

	// true clock next state: slots, input capture, read pipeline
	always_comb begin
		slot_next = slot_reg;
		unique case (slot_reg)
			SLOT_READ: slot_next = SLOT_WRITE; // see R02
			SLOT_WRITE: slot_next = SLOT_READ;
		endcase
		cap_slot_next = slot_reg;
		addr_in_next = I_ADDR; // see R09
		wdata_in_next = I_WDATA; // see R15
		rps_n_in_next = I_READ_PORT_SELECT_N;
		wps_n_in_next = I_WRITE_PORT_SELECT_N;
		rd_pend_next = byp_k && rd_req; // see R05
		rd_addr_p_next = addr_in_reg;
		rdata_k_next = rdata_k_reg;
		rd_w1_stage_next = rd_w1_stage_reg;
		if (launch) begin
			rdata_k_next = mem[word_index(launch_addr, 1'h0)]; // see R03 see R10
			rd_w1_stage_next = mem[word_index(launch_addr, 1'h1)];
		end
		valid_next = launch; // see R07
		wr_tog_next = wr_tog_reg ^ wr_en; // see R11
		echo_k_next = ~echo_k_reg; // see R13
		if (k_rst) begin
			slot_next = SLOT_RST;
			cap_slot_next = SLOT_RST;
			addr_in_next = ADDR_RST;
			wdata_in_next = DATA_RST;
			rps_n_in_next = SEL_N_RST;
			wps_n_in_next = SEL_N_RST;
			rd_pend_next = FLAG_RST;
			rd_addr_p_next = ADDR_RST;
			rdata_k_next = DATA_RST;
			rd_w1_stage_next = DATA_RST;
			valid_next = FLAG_RST;
			wr_tog_next = FLAG_RST;
			echo_k_next = FLAG_RST;
		end
	end

	// true clock registers, rising edge only
	always_ff @(posedge I_K_CLK) begin // see R12
		slot_reg <= slot_next;
		cap_slot_reg <= cap_slot_next;
		addr_in_reg <= addr_in_next;
		wdata_in_reg <= wdata_in_next;
		rps_n_in_reg <= rps_n_in_next;
		wps_n_in_reg <= wps_n_in_next;
		rd_pend_reg <= rd_pend_next;
		rd_addr_p_reg <= rd_addr_p_next;
		rdata_k_reg <= rdata_k_next;
		rd_w1_stage_reg <= rd_w1_stage_next;
		valid_reg <= valid_next;
		wr_tog_reg <= wr_tog_next;
		echo_k_reg <= echo_k_next;
	end

	// self-timed array write of both burst words
	always_ff @(posedge I_K_CLK) begin
		if (wr_en && !k_rst) begin
			mem[w0_idx] <= wdata_in_reg; // see R11 see R01
			mem[w1_idx] <= wdata_kn_reg; // see R15
		end
	end

	// complement clock next state: second write word, second read word, echo
	always_comb begin
		wdata_kn_next = I_WDATA; // see R09 see R04
		rdata_kn_next = rd_w1_stage_reg; // see R15 see R10
		echo_kn_next = ~echo_kn_reg;
		if (kn_rst) begin
			wdata_kn_next = DATA_RST;
			rdata_kn_next = DATA_RST;
			echo_kn_next = FLAG_RST;
		end
	end

	// complement clock registers, rising edge only
	always_ff @(posedge I_K_CLK_N) begin // see R12
		wdata_kn_reg <= wdata_kn_next;
		rdata_kn_reg <= rdata_kn_next;
		echo_kn_reg <= echo_kn_next;
	end

	// output assignments
	assign O_RDATA_K = rdata_k_reg;
	assign O_RDATA_KN = rdata_kn_reg;
	assign O_READ_VALID_FLAG = valid_reg;
	assign O_ECHO_TIMING_OUT = echo_k_reg ^ echo_kn_reg; // see R13
	assign O_ECHO_TIMING_OUT_N = ~(echo_k_reg ^ echo_kn_reg);
	assign O_WRITE_DONE = write_done_reg;

	// slot alternates on every true edge
	property p_slot_alt;
		@(posedge I_K_CLK) disable iff (k_rst)
		slot_reg == SLOT_READ |=> slot_reg == SLOT_WRITE ##1 slot_reg == SLOT_READ;
	endproperty
	a_slot_alt: assert property (p_slot_alt) else $error("address slots do not alternate"); // see R02

	// bypass high gives two-cycle read latency
	property p_lat_pll;
		@(posedge I_K_CLK) disable iff (k_rst)
		(rd_req && byp_k) ##1 byp_k |-> !valid_reg ##1 valid_reg;
	endproperty
	a_lat_pll: assert property (p_lat_pll) else $error("read latency is not two cycles"); // see R05

	// bypass low gives one-cycle read latency
	property p_lat_legacy;
		@(posedge I_K_CLK) disable iff (k_rst)
		rd_req && !byp_k |=> valid_reg;
	endproperty
	a_lat_legacy: assert property (p_lat_legacy) else $error("read latency is not one cycle"); // see R06

	// valid only follows a real read
	property p_valid_cause;
		@(posedge I_K_CLK) disable iff (k_rst)
		$rose(valid_reg) |-> $past(rd_req && !byp_k) || $past(rd_pend_reg);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("valid flag without a read"); // see R07

	// no read start with bypass low when the read port is deselected
	property p_no_read;
		@(posedge I_K_CLK) disable iff (k_rst)
		!rd_req && !rd_pend_reg ##0 !byp_k |=> !valid_reg;
	endproperty
	a_no_read: assert property (p_no_read) else $error("read burst started while deselected"); // see R16

	// deselected write slot writes nothing
	property p_no_write;
		@(posedge I_K_CLK) disable iff (k_rst)
		cap_slot_reg == SLOT_WRITE && wps_n_in_reg |=> $stable(wr_tog_reg);
	endproperty
	a_no_write: assert property (p_no_write) else $error("array written while deselected"); // see R08

	// both burst words land in the array one edge after capture
	property p_write_commit;
		@(posedge I_K_CLK) disable iff (k_rst)
		wr_en |=> mem[$past(w0_idx)] == $past(wdata_in_reg) && mem[$past(w1_idx)] == $past(wdata_kn_reg);
	endproperty
	a_write_commit: assert property (p_write_commit) else $error("burst write not committed"); // see R11

	// first word of a legacy-latency burst comes from the captured address
	property p_burst_word;
		@(posedge I_K_CLK) disable iff (k_rst)
		rd_req && !byp_k && !wr_en |=> rdata_k_reg == mem[word_index($past(addr_in_reg), 1'h0)];
	endproperty
	a_burst_word: assert property (p_burst_word) else $error("read word does not match array"); // see R03

	// echo clock keeps running
	property p_echo_run;
		@(posedge I_K_CLK) disable iff (k_rst)
		1'h1 |=> echo_k_reg != $past(echo_k_reg);
	endproperty
	a_echo_run: assert property (p_echo_run) else $error("echo clock stopped"); // see R13

	// main scenarios
	property p_cov_read_pll;
		@(posedge I_K_CLK) disable iff (k_rst)
		rd_req && byp_k ##2 valid_reg;
	endproperty
	c_cov_read_pll: cover property (p_cov_read_pll);

	property p_cov_read_legacy;
		@(posedge I_K_CLK) disable iff (k_rst)
		rd_req && !byp_k ##1 valid_reg;
	endproperty
	c_cov_read_legacy: cover property (p_cov_read_legacy);

	property p_cov_rd_wr;
		@(posedge I_K_CLK) disable iff (k_rst)
		rd_req ##1 wr_en;
	endproperty
	c_cov_rd_wr: cover property (p_cov_rd_wr);

endmodule : sidbsp_port_top

/* core/sidbsp_pkg.sv */
// shared constants and types for the separate-port ddr burst sram block
package sidbsp_pkg;

	// word and array geometry (wide configuration)
	localparam int DATA_W = 36;
	localparam int ADDR_W = 8;
	localparam int BURST_LEN = 2;
	localparam int DEPTH = (1 << ADDR_W) * BURST_LEN;

	// read latency in link clock cycles, by bypass level
	localparam int LAT_PLL = 2;
	localparam int LAT_LEGACY = 1;

	// link clock ceiling, kept for reference by the far side
	localparam int K_FMAX_MHZ = 250;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

	// values after reset
	localparam logic SEL_N_RST = 1'h1;
	localparam logic FLAG_RST = 1'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h0;

	// slot of the shared address bus on a true clock edge
	typedef enum logic {
		SLOT_READ,
		SLOT_WRITE
	} sidbsp_slot_t;

	localparam sidbsp_slot_t SLOT_RST = SLOT_READ;

	// array index of one word of a burst
	function automatic logic [ADDR_W:0] word_index(input logic [ADDR_W-1:0] addr, input logic word);
		word_index = {addr, word};
	endfunction : word_index

endpackage : sidbsp_pkg

/* core/sidbsp_sync.sv */
`timescale 1ns/1ps
// two flip-flop level synchroniser
module sidbsp_sync (
	// destination clock
	input wire logic i_clk,
	// level from another domain
	input wire logic i_d,
	// synchronised level
	output logic o_q
);
	logic meta_reg;
	logic q_reg;
	logic meta_next;
	logic q_next;

	// only the second stage reads the first
	always_comb begin
		meta_next = i_d;
		q_next = meta_reg;
	end

	always_ff @(posedge i_clk) begin
		meta_reg <= meta_next;
		q_reg <= q_next;
	end

	assign o_q = q_reg;

endmodule : sidbsp_sync

/* bench/sidbsp_ctrl_model.sv */
`timescale 1ns/1ps
// behavioural memory controller at the far side of the link
module sidbsp_ctrl_model
	import sidbsp_pkg::*;
(
	// link clocks
	output logic o_k_clk,
	output logic o_k_clk_n,
	// selects, shared address, write data
	output logic o_rps_n,
	output logic o_wps_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_wdata
);
	logic par = 1'h0;
	logic rd_par = 1'h0;

	// true clock, 32 ns, well under the link ceiling, offset from system clock
	initial begin
		o_k_clk = 1'h0;
		#7;
		forever #16 o_k_clk = ~o_k_clk;
	end
	assign o_k_clk_n = ~o_k_clk;

	// parity of the last true clock edge
	always @(posedge o_k_clk) begin
		par <= ~par;
	end

	// idle levels at time zero
	initial begin
		o_rps_n = 1'h1;
		o_wps_n = 1'h1;
		o_addr = 8'h5A;
		o_wdata = 36'hA5A5A5A5A;
	end

	// parity that marks a read slot
	task automatic set_phase(input logic p);
		rd_par = p;
	endtask : set_phase

	// wait until the coming true edge is the wanted slot
	task automatic align(input logic want_read);
		@(posedge o_k_clk);
		#2;
		if ((par != rd_par) != want_read) begin
			@(posedge o_k_clk);
			#2;
		end
	endtask : align

	// read request held over one true edge, address then scrambled
	task automatic read_burst(input logic [ADDR_W-1:0] a, input logic sel_n);
		align(1'h1);
		o_rps_n = sel_n;
		o_addr = a;
		@(posedge o_k_clk);
		#2;
		o_rps_n = 1'h1;
		o_addr = ~a;
	endtask : read_burst

	// write request, word0 on true edge, word1 on next complement edge
	task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
		input logic sel_n);
		align(1'h0);
		o_wps_n = sel_n;
		o_addr = a;
		o_wdata = d0;
		@(posedge o_k_clk);
		#2;
		o_wps_n = 1'h1;
		o_addr = ~a;
		o_wdata = d1;
		@(posedge o_k_clk_n);
		#2;
		o_wdata = ~d1;
	endtask : write_burst
endmodule : sidbsp_ctrl_model

/* bench/sidbsp_port_top_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the separate-port burst sram block
module sidbsp_port_top_tb
	import sidbsp_pkg::*;
;
	logic sys_clk;
	logic resetn;
	logic bypass;
	logic k;
	logic kn;
	logic rps_n;
	logic wps_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata_k;
	logic [DATA_W-1:0] rdata_kn;
	logic valid;
	logic echo;
	logic echo_n;
	logic write_done;
	int errors = 0;
	int n_tests = 0;
	int n_done = 0;
	int n_wr = 0;
	logic [DATA_W-1:0] mem_exp [0:DEPTH-1];
	logic [ADDR_W-1:0] aq [$];

	sidbsp_ctrl_model i_sidbsp_ctrl_model (.o_k_clk(k), .o_k_clk_n(kn), .o_rps_n(rps_n), .o_wps_n(wps_n),
		.o_addr(addr), .o_wdata(wdata));

	sidbsp_port_top i_sidbsp_port_top (.I_SYS_CLK(sys_clk), .I_RESETN(resetn), .I_K_CLK(k), .I_K_CLK_N(kn),
		.I_PLL_BYPASS_SELECT(bypass), .I_READ_PORT_SELECT_N(rps_n), .I_WRITE_PORT_SELECT_N(wps_n),
		.I_ADDR(addr), .I_WDATA(wdata), .O_RDATA_K(rdata_k), .O_RDATA_KN(rdata_kn),
		.O_READ_VALID_FLAG(valid), .O_ECHO_TIMING_OUT(echo), .O_ECHO_TIMING_OUT_N(echo_n),
		.O_WRITE_DONE(write_done));

	// system clock, 20 ns
	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end

	// committed write pulses, sampled away from the launching edge
	always @(negedge sys_clk) begin
		if (write_done === 1'h1) begin
			n_done <= n_done + 1;
		end
	end

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// write burst, expectation kept only when selected
	task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
		input logic sel_n);
		i_sidbsp_ctrl_model.write_burst(a, d0, d1, sel_n);
		if (sel_n == 1'h0) begin
			mem_exp[{a, 1'h0}] = d0;
			mem_exp[{a, 1'h1}] = d1;
			n_wr++;
		end
	endtask : do_write

	// read burst with exact latency and valid window
	task automatic do_read(input logic [ADDR_W-1:0] a, input int lat);
		i_sidbsp_ctrl_model.read_burst(a, 1'h0);
		// first true edge after the capture edge
		@(posedge k);
		#2;
		if (lat == LAT_PLL) begin
			check(36'(valid), 36'h0);
			@(posedge k);
			#2;
		end
		check(36'(valid), 36'h1);
		check(rdata_k, mem_exp[{a, 1'h0}]);
		@(posedge kn);
		#2;
		check(rdata_kn, mem_exp[{a, 1'h1}]);
		@(posedge k);
		#2;
		check(36'(valid), 36'h0);
	endtask : do_read

	initial begin
		#200000;
		errors++;
		results();
	end

	initial begin
		int seed;
		int i;
		logic hit;
		resetn = 1'h0;
		bypass = 1'h0;
		seed = $urandom(32'h0dc6);
		repeat (10) @(posedge sys_clk);
		#2;
		check(36'(valid), 36'h0);
		check(rdata_k, 36'h0);
		check(36'({echo, echo_n}), 36'h1);
		resetn = 1'h1;
		repeat (8) @(posedge k);
		// find which true edge parity is the read slot
		i_sidbsp_ctrl_model.read_burst(8'h00, 1'h0);
		// a read slot would show valid one edge after capture
		@(posedge k);
		#2;
		hit = (valid === 1'h1);
		repeat (3) @(posedge k);
		if (!hit) begin
			i_sidbsp_ctrl_model.set_phase(1'h1);
		end
		for (i = 0; i < 12; i++) begin
			aq.push_back((i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom()));
			do_write(aq[i], {$urandom(), 4'($urandom())}, {$urandom(), 4'($urandom())}, 1'h0);
		end
		// deselected write leaves the array alone
		do_write(8'h00, 36'hFFFFFFFFF, 36'h123456789, 1'h1);
		for (i = 0; i < 6; i++) begin
			do_read(aq[i], LAT_LEGACY);
		end
		// deselected read gives no burst
		i_sidbsp_ctrl_model.read_burst(8'hFF, 1'h1);
		repeat (3) begin
			@(posedge k);
			#2;
			check(36'(valid), 36'h0);
		end
		bypass = 1'h1;
		repeat (4) @(posedge k);
		for (i = 6; i < 12; i++) begin
			do_read(aq[i], LAT_PLL);
		end
		do_read(8'hFF, LAT_PLL);
		// echo pair is complementary after each true edge and changes on every complement edge
		repeat (6) begin
			@(posedge k);
			#4;
			hit = echo;
			check(36'(echo_n), 36'(!echo));
			@(posedge kn);
			#4;
			check(36'(echo), 36'(!hit));
		end
		repeat (10) @(posedge sys_clk);
		check(36'(n_done), 36'(n_wr));
		results();
	end
endmodule : sidbsp_port_top_tb
